// ### verilog/mq_read_port.sv
// Function
// RL1: A queue word is read on a read-clock edge only with read enable low.
// RL2: Queue selection is taken regardless of read enable.
// RL3: New queue data appears on the second read-clock edge after selection.
// RL4: Flag bus polling and quadrant selection need no read enable.
// RL5: Data bus is driven only with chip select and read enable both low.
// RL6: Chip select is ignored during master reset.
// RL7: Read address bus is 8 bits, for queue or quadrant selection.
// RL8: Low five address bits name the queue.
// RL9: Upper three address bits must match the device code to act.
// RL10: Quadrant comes from the low four bits; bit four ignored.
// RL11: Empty flag and flag bus change on the read clock.
// RL12: Expansion token out and in are timed by the read clock.
// RL13: Controller supplies a free-running read clock.
// RL14: Serial bit shifts in on serial-clock edge while chain enable is low.
// RL15: All chained devices share one serial clock source.
// RL16: Chain done output follows enable input once programming is done.
// RL17: Normal reads start only after the chain done output went low.
// RL18: First enable comes from controller, later ones from previous device.
// RL19: After loading, serial data passes through to the next device.
// RL20: Setup registers are shift registers fed from serial data.
// RL21: Controller watches the last device's done output for completion.
// RL22: Queue on the address bus is taken when select strobe is high.
// RL23: Controller never raises both strobes together or before programming.
// RL24: Direct mode takes the quadrant when the quadrant strobe is high.
// RL25: A non-matching device keeps its queue and floats its data bus.
`include "mq_defines.svh"

module mq_read_port
  import mq_pkg::*;
#(
  parameter int QUEUES = `MQ_QUEUES,
  parameter int DATA_W = `MQ_DATA_W,
  parameter int CFG_BITS = `MQ_CFG_BITS
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic master_reset_n,
  input wire logic read_clk,
  input wire logic read_en_n,
  input wire logic read_chip_select_n,
  input wire logic read_queue_select_strobe,
  input wire logic empty_quadrant_strobe,
  input wire logic [`MQ_ADDR_W-1:0] read_queue_address,
  input wire logic [`MQ_ID_W-1:0] device_select_code,
  input wire logic flag_direct_mode,
  input wire logic serial_prog_mode,
  input wire logic serial_clk,
  input wire logic config_chain_enable_in,
  input wire logic serial_data_in,
  input wire logic expansion_token_in,
  input wire logic [DATA_W-1:0] queue_word,
  input wire logic [QUEUES-1:0] queue_empty,
  input wire logic [QUEUES-1:0] queue_almost_empty,
  output logic [`MQ_QIDX_W-1:0] read_queue,
  output logic read_pop,
  output logic [DATA_W-1:0] read_data,
  output logic read_data_oe,
  output logic empty_flag_n,
  output logic [`MQ_FLAG_W-1:0] almost_empty_flag_bus,
  output logic almost_empty_flag_oe,
  output logic expansion_token_out,
  output logic config_chain_done_out,
  output logic serial_data_out,
  output logic [CFG_BITS-1:0] config_word
);

  initial begin
    if (QUEUES != `MQ_FLAG_W << `MQ_QUAD_W || DATA_W < 1) begin
      $error("mq_read_port: unsupported QUEUES or DATA_W");
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  mq_rd_pins_s rd_m, rd_s;
  mq_ser_pins_s ser_m, ser_s;
  logic [`MQ_ID_W+3:0] misc_m, misc_s;
  logic rclk_d, sclk_d;

  wire mq_rd_pins_s rd_raw = '{read_clk, read_en_n, read_chip_select_n,
                               read_queue_select_strobe, empty_quadrant_strobe,
                               read_queue_address};
  wire mq_ser_pins_s ser_raw = '{serial_clk, config_chain_enable_in, serial_data_in};
  wire [`MQ_ID_W+3:0] misc_raw = {device_select_code, flag_direct_mode,
                                  serial_prog_mode, master_reset_n, expansion_token_in};

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_m <= '0;
      rd_s <= '0;
      ser_m <= '0;
      ser_s <= '0;
      misc_m <= '0;
      misc_s <= '0;
      rclk_d <= 1'b0;
      sclk_d <= 1'b0;
    end else begin
      rd_m <= rd_raw;
      rd_s <= rd_m;
      ser_m <= ser_raw;
      ser_s <= ser_m;
      misc_m <= misc_raw;
      misc_s <= misc_m;
      rclk_d <= rd_s.clk;
      sclk_d <= ser_s.clk;
    end
  end

  wire [`MQ_ID_W-1:0] id_pins = misc_s[`MQ_ID_W+3:4];
  wire direct_pin = misc_s[3];
  wire serial_pin = misc_s[2];
  wire mrs_act = !misc_s[1];
  wire token_in = misc_s[0];
  // Read clock must run free; edges are seen by sampling
  wire rclk_rise = rd_s.clk && !rclk_d; // RL11 RL12 RL13
  wire sclk_rise = ser_s.clk && !sclk_d;

  // ****************************************
  // Straps sampled during master reset, held after it
  // ****************************************
  logic [`MQ_ID_W-1:0] id_code;
  logic direct_mode;
  logic serial_mode;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      id_code <= '0;
      direct_mode <= 1'b0;
      serial_mode <= 1'b0;
    end else if (mrs_act) begin
      id_code <= id_pins;
      direct_mode <= direct_pin;
      serial_mode <= serial_pin;
    end
  end

  logic cfg_done;

  mq_cfg_chain #(
    .CFG_BITS(CFG_BITS)
  ) u_cfg (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .mrs_act(mrs_act),
    .serial_mode(serial_mode),
    .sclk_rise(sclk_rise),
    .config_chain_enable_in_n(ser_s.en_n),
    .si(ser_s.data),
    .cfg_done(cfg_done),
    .config_chain_done_out_n(config_chain_done_out),
    .so(serial_data_out),
    .cfg_word(config_word)
  );

  // Sticky: reads wait for the done output, not only for the shifter
  logic prog_ready;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_ready <= 1'b0;
    end else if (mrs_act) begin
      prog_ready <= 1'b0;
    end else if (cfg_done && !config_chain_done_out) begin
      prog_ready <= 1'b1; // RL17
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic mq_id_hit(input logic [`MQ_ADDR_W-1:0] a,
                                     input logic [`MQ_ID_W-1:0] id);
    mq_id_hit = a[`MQ_ADDR_W-1:`MQ_ID_LSB] == id;
  endfunction

  wire live = rclk_rise && prog_ready && !mrs_act; // RL17
  wire sel_take = live && rd_s.sel; // RL2 RL22
  wire sel_hit = sel_take && mq_id_hit(rd_s.addr, id_code); // RL9
  wire sel_miss = sel_take && !mq_id_hit(rd_s.addr, id_code); // RL25
  wire quad_take = live && direct_mode && rd_s.qstr &&
                   mq_id_hit(rd_s.addr, id_code); // RL4 RL24
  wire ren_act = !rd_s.en_n;

  logic [`MQ_QIDX_W-1:0] pend_q;
  logic pend;
  logic load;
  logic dev_sel;
  logic tok_seen;
  logic [`MQ_QUAD_W-1:0] quad;

  // ****************************************
  // Queue selection and read pipeline
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= `MQ_QUEUE_RST;
      pend <= 1'b0;
      load <= 1'b0;
      dev_sel <= 1'b0;
      read_queue <= `MQ_QUEUE_RST;
      expansion_token_out <= 1'b0;
    end else if (mrs_act) begin
      pend <= 1'b0;
      load <= 1'b0;
      dev_sel <= 1'b0;
      read_queue <= `MQ_QUEUE_RST;
      expansion_token_out <= 1'b0;
    end else if (rclk_rise) begin
      expansion_token_out <= 1'b0;
      if (sel_hit) begin
        pend_q <= rd_s.addr[`MQ_QIDX_W-1:0]; // RL7 RL8
        dev_sel <= 1'b1;
      end else if (sel_miss && dev_sel) begin
        dev_sel <= 1'b0; // RL25
        expansion_token_out <= 1'b1; // RL12
      end
      pend <= sel_hit;
      load <= pend;
      if (pend) begin
        read_queue <= pend_q;
      end
    end
  end

  // Read fires on a read-clock edge only, with read enable low
  assign read_pop = live && ren_act && dev_sel && !pend && !load; // RL1

  // ****************************************
  // Data, flags and token
  // ****************************************
  wire [`MQ_QUEUES/`MQ_FLAG_W*`MQ_FLAG_W-1:0] ae_all = queue_almost_empty;
  wire [`MQ_FLAG_W-1:0] ae_quad = ae_all[{quad, 3'b000} +: `MQ_FLAG_W];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      read_data <= '0;
      empty_flag_n <= 1'b0;
      almost_empty_flag_bus <= '1;
      quad <= `MQ_QUAD_RST;
      tok_seen <= 1'b0;
    end else if (mrs_act) begin
      empty_flag_n <= 1'b0;
      almost_empty_flag_bus <= '1;
      quad <= `MQ_QUAD_RST;
      tok_seen <= 1'b0;
    end else if (rclk_rise) begin
      if ((load || read_pop) && cfg_done) begin
        read_data <= queue_word; // RL3 RL1
      end
      empty_flag_n <= !queue_empty[read_queue]; // RL11
      almost_empty_flag_bus <= ~ae_quad; // RL11
      tok_seen <= token_in; // RL12
      if (quad_take) begin
        quad <= rd_s.addr[`MQ_QUAD_W-1:0]; // RL10 RL24
      end else if (!direct_mode && cfg_done) begin
        quad <= quad + `MQ_QUAD_W'(1); // RL4
      end
    end
  end

  // Chip select is a don't care during master reset
  assign read_data_oe = !mrs_act && dev_sel && !rd_s.cs_n && ren_act; // RL5 RL6
  // Bus floats when another device holds the read side
  assign almost_empty_flag_oe = !mrs_act && (dev_sel || tok_seen);

  // ****************************************
  // Checks
  // ****************************************
  sequence s_new_queue;
    sel_hit;
  endsequence

  sequence s_commit;
    pend && rclk_rise && !mrs_act;
  endsequence

  property p_sel_pend;
    @(posedge ref_clk) disable iff (!rst_b)
    s_new_queue |=> pend && pend_q == $past(rd_s.addr[`MQ_QIDX_W-1:0]);
  endproperty
  a_sel_pend: assert property (p_sel_pend) else $error("selection not held"); // RL22

  property p_pop_ren;
    @(posedge ref_clk) disable iff (!rst_b)
    read_pop |-> !rd_s.en_n && rclk_rise;
  endproperty
  a_pop_ren: assert property (p_pop_ren) else $error("read without read enable"); // RL1

  property p_new_data;
    @(posedge ref_clk) disable iff (!rst_b)
    (load && rclk_rise && !mrs_act) |=> read_data == $past(queue_word);
  endproperty
  a_new_data: assert property (p_new_data) else $error("new queue data late"); // RL3

  property p_sel_queue;
    @(posedge ref_clk) disable iff (!rst_b)
    s_commit |=> read_queue == $past(pend_q);
  endproperty
  a_sel_queue: assert property (p_sel_queue) else $error("selected queue not taken"); // RL22

  property p_miss_keep;
    @(posedge ref_clk) disable iff (!rst_b)
    sel_miss |=> read_queue == $past(read_queue) && !dev_sel;
  endproperty
  a_miss_keep: assert property (p_miss_keep) else $error("foreign selection changed queue"); // RL25

  property p_oe;
    @(posedge ref_clk) disable iff (!rst_b)
    read_data_oe |-> !rd_s.cs_n && !rd_s.en_n && dev_sel;
  endproperty
  a_oe: assert property (p_oe) else $error("data driven without enables"); // RL5

  property p_mrs_float;
    @(posedge ref_clk) disable iff (!rst_b)
    mrs_act |-> !read_data_oe;
  endproperty
  a_mrs_float: assert property (p_mrs_float) else $error("data driven in master reset"); // RL6

  property p_poll;
    @(posedge ref_clk) disable iff (!rst_b)
    (rclk_rise && !direct_mode && cfg_done && !mrs_act) |=> quad == $past(quad) + 4'h1;
  endproperty
  a_poll: assert property (p_poll) else $error("flag bus not polled"); // RL4

  property p_ready;
    @(posedge ref_clk) disable iff (!rst_b)
    read_pop |-> cfg_done && prog_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("read before programming done"); // RL17

endmodule // mq_read_port

// ### verilog/mq_defines.svh
`ifndef MQ_DEFINES_SVH
`define MQ_DEFINES_SVH

`define MQ_ADDR_W 8
`define MQ_QIDX_W 5
`define MQ_QUAD_W 4
`define MQ_ID_W 3
`define MQ_ID_LSB 5
`define MQ_FLAG_W 8
`define MQ_QUEUES 128
`define MQ_DATA_W 40
`define MQ_CFG_BITS 64
`define MQ_CFG_CNT_W 7
`define MQ_QUEUE_RST 5'h00
`define MQ_QUAD_RST 4'h0

`endif

// ### verilog/mq_pkg.sv
`include "mq_defines.svh"

package mq_pkg;

  // Read side pins sampled together
  typedef struct packed {
    logic clk;
    logic en_n;
    logic cs_n;
    logic sel;
    logic qstr;
    logic [`MQ_ADDR_W-1:0] addr;
  } mq_rd_pins_s;

  // Serial chain pins sampled together
  typedef struct packed {
    logic clk;
    logic en_n;
    logic data;
  } mq_ser_pins_s;

  typedef enum logic [1:0] {
    MQ_CFG_IDLE,
    MQ_CFG_SHIFT,
    MQ_CFG_DONE
  } mq_cfg_e;

endpackage

// ### verilog/mq_cfg_chain.sv
`include "mq_defines.svh"

module mq_cfg_chain
  import mq_pkg::*;
#(
  parameter int CFG_BITS = `MQ_CFG_BITS
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic mrs_act,
  input wire logic serial_mode,
  input wire logic sclk_rise,
  input wire logic config_chain_enable_in_n,
  input wire logic si,
  output logic cfg_done,
  output logic config_chain_done_out_n,
  output logic so,
  output logic [CFG_BITS-1:0] cfg_word
);

  initial begin
    if (CFG_BITS < 2 || CFG_BITS > (1 << `MQ_CFG_CNT_W)) begin
      $error("mq_cfg_chain: CFG_BITS out of range");
    end
  end

  mq_cfg_e state;
  logic [`MQ_CFG_CNT_W-1:0] cnt;
  wire shift_take = sclk_rise && !config_chain_enable_in_n && state == MQ_CFG_SHIFT;
  wire last_bit = cnt == `MQ_CFG_CNT_W'(CFG_BITS - 1);

  // ****************************************
  // Setup shift register
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= MQ_CFG_IDLE;
      cnt <= '0;
      cfg_word <= '0;
    end else if (mrs_act) begin
      state <= MQ_CFG_IDLE;
      cnt <= '0;
    end else begin
      unique case (state)
        MQ_CFG_IDLE: begin
          // Without serial mode the word already in cfg_word stands at once
          state <= serial_mode ? MQ_CFG_SHIFT : MQ_CFG_DONE;
        end
        MQ_CFG_SHIFT: begin
          if (shift_take) begin
            cfg_word <= {cfg_word[CFG_BITS-2:0], si}; // RL14 RL20
            cnt <= cnt + `MQ_CFG_CNT_W'(1);
            if (last_bit) begin
              state <= MQ_CFG_DONE;
            end
          end
        end
        MQ_CFG_DONE: begin
          state <= MQ_CFG_DONE;
        end
      endcase
    end
  end

  assign cfg_done = state == MQ_CFG_DONE;

  // Registered so both outputs stand glitch free
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      config_chain_done_out_n <= 1'b1;
      so <= 1'b0;
    end else begin
      config_chain_done_out_n <= cfg_done ? config_chain_enable_in_n : 1'b1; // RL16
      so <= cfg_done ? si : cfg_word[CFG_BITS-1]; // RL19
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_shift_edge;
    sclk_rise && !config_chain_enable_in_n && state == MQ_CFG_SHIFT && !mrs_act;
  endsequence

  property p_shift_in;
    @(posedge ref_clk) disable iff (!rst_b)
    s_shift_edge |=> cfg_word[0] == $past(si);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in"); // RL14

  property p_pass_through;
    @(posedge ref_clk) disable iff (!rst_b)
    cfg_done |=> so == $past(si);
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("serial data not passed on"); // RL19

  property p_config_chain_done_out_follow;
    @(posedge ref_clk) disable iff (!rst_b)
    !cfg_done |=> config_chain_done_out_n;
  endproperty
  a_config_chain_done_out_follow: assert property (p_config_chain_done_out_follow) else $error("enable out low before done"); // RL16

endmodule // mq_cfg_chain

// ### dv/mq_queue_model.sv
// ********************
// Queue storage stub
// ********************
module mq_queue_model
  import mq_pkg::*;
#(
  parameter int DATA_W = 40,
  parameter int QUEUES = 128,
  parameter logic [127:0] EMPTY_MAP = 128'h8,
  parameter logic [127:0] AE_MAP = 128'h0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [4:0] read_queue,
  input wire logic read_pop,
  output logic [DATA_W-1:0] queue_word,
  output logic [QUEUES-1:0] queue_empty,
  output logic [QUEUES-1:0] queue_almost_empty
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] rd_ptr [32];
  // Word carries queue and position, so a wrong queue or lost pop shows
  assign queue_word = DATA_W'({8'(read_queue), rd_ptr[read_queue]});
  assign queue_empty = EMPTY_MAP[QUEUES-1:0];
  assign queue_almost_empty = AE_MAP[QUEUES-1:0];
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 32; i++) rd_ptr[i] <= 16'h0000;
    end else if (read_pop) begin
      rd_ptr[read_queue] <= rd_ptr[read_queue] + 16'h0001;
    end
  end
endmodule // mq_queue_model

// ### dv/test_multiqueue_read_port_serial_config.sv
module test_multiqueue_read_port_serial_config
  import mq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [127:0] AE = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  localparam logic [63:0] CFG = 64'hc3a5_1e0f_9687_2d4b;
  typedef struct packed {
    logic [7:0] addr;
    logic [4:0] q;
    logic efn;
  } mq_row_s;
  logic ref_clk = 1'b0, rst_b = 1'b0, master_reset_n = 1'b0, read_clk;
  logic read_en_n = 1'b1, read_chip_select_n = 1'b1, sel = 1'b0, qstr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic serial_clk = 1'b0, chain_en_n = 1'b0, sdi = 1'b0;
  logic [2:0] rdiv = 3'h0;
  logic [4:0] read_queue;
  logic read_pop, read_data_oe, empty_flag_n, done_n, sdo;
  logic [39:0] read_data, queue_word;
  logic [127:0] queue_empty, queue_almost_empty;
  logic [7:0] almost_empty_flag_bus;
  logic [63:0] config_word;
  logic flag_direct = 1'b1, serial_prog = 1'b1, token, flag_oe;
  logic [7:0] bus1;
  int k;
  int fails = 0, num_checks = 0, pops = 0;
  mq_row_s rows [5] = '{'{8'ha3, 5'h03, 1'b0}, '{8'ha7, 5'h07, 1'b1},
    '{8'h63, 5'h07, 1'b1}, '{8'hbf, 5'h1f, 1'b1}, '{8'ha2, 5'h02, 1'b1}};
  logic [7:0] qa [3] = '{8'ha5, 8'hb9, 8'h2c};
  logic [3:0] qe [3] = '{4'h5, 4'h9, 4'h9};

  // ********************
  // Clocks and stubs
  // ********************
  always #20 ref_clk = ~ref_clk;
  // Read clock never stops, even between tests
  always @(negedge ref_clk) rdiv <= rdiv + 3'h1;
  assign read_clk = rdiv[2];
  always @(posedge ref_clk) if (read_pop === 1'b1) pops++;

  mq_queue_model #(.AE_MAP(AE)) u_mq_queue_model (.ref_clk(ref_clk), .rst_b(rst_b),
    .read_queue(read_queue), .read_pop(read_pop), .queue_word(queue_word),
    .queue_empty(queue_empty), .queue_almost_empty(queue_almost_empty));

  mq_read_port u_mq_read_port (.ref_clk(ref_clk), .rst_b(rst_b),
    .master_reset_n(master_reset_n), .read_clk(read_clk), .read_en_n(read_en_n),
    .read_chip_select_n(read_chip_select_n), .read_queue_select_strobe(sel),
    .empty_quadrant_strobe(qstr), .read_queue_address(addr),
    .device_select_code(3'h5), .flag_direct_mode(flag_direct), .serial_prog_mode(serial_prog),
    .serial_clk(serial_clk), .config_chain_enable_in(chain_en_n),
    .serial_data_in(sdi), .expansion_token_in(1'b0), .queue_word(queue_word),
    .queue_empty(queue_empty), .queue_almost_empty(queue_almost_empty),
    .read_queue(read_queue), .read_pop(read_pop), .read_data(read_data),
    .read_data_oe(read_data_oe), .empty_flag_n(empty_flag_n),
    .almost_empty_flag_bus(almost_empty_flag_bus), .almost_empty_flag_oe(flag_oe),
    .expansion_token_out(token), .config_chain_done_out(done_n),
    .serial_data_out(sdo), .config_word(config_word));

  // ********************
  // Helpers
  // ********************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic sbit(input logic b);
    sdi = b;
    repeat (4) @(negedge ref_clk);
    serial_clk = 1'b1;
    repeat (4) @(negedge ref_clk);
    serial_clk = 1'b0;
  endtask

  task automatic rwait(input int n);
    repeat (n) @(negedge read_clk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    report_and_stop();
  end

  // ********************
  // Tests
  // ********************
  initial begin
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge ref_clk);
    master_reset_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk(done_n, 1'b1, "done before load");
    for (int i = 63; i >= 0; i--) sbit(CFG[i]);
    repeat (8) @(negedge ref_clk);
    chk(config_word, CFG, "setup word");
    chk(done_n, 1'b0, "done after load");
    for (int b = 0; b < 2; b++) begin
      sdi = b[0];
      repeat (4) @(negedge ref_clk);
      chk(sdo, b[0], "pass through");
    end
    chain_en_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(done_n, 1'b1, "done follows high");
    chain_en_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(done_n, 1'b0, "done follows low");
    // Selection with read enable high: data must still arrive
    foreach (rows[i]) begin
      rwait(1);
      addr = rows[i].addr;
      sel = 1'b1;
      rwait(1);
      sel = 1'b0;
      rwait(2);
      chk(read_queue, rows[i].q, "queue select");
      chk(read_data, {8'(rows[i].q), 16'h0000}, "new queue data");
      chk(empty_flag_n, rows[i].efn, "empty flag");
    end
    foreach (qa[i]) begin
      addr = qa[i];
      qstr = 1'b1;
      rwait(1);
      qstr = 1'b0;
      rwait(2);
      chk(almost_empty_flag_bus, 8'(~AE[qe[i]*8 +: 8]), "quadrant bus");
    end
    pops = 0;
    read_chip_select_n = 1'b0;
    read_en_n = 1'b0;
    rwait(3);
    chk(pops, 3, "pop count");
    chk(read_data_oe, 1'b1, "bus driven");
    chk(flag_oe, 1'b1, "flag bus driven");
    read_chip_select_n = 1'b1;
    rwait(1);
    chk(read_data_oe, 1'b0, "bus off cs high");
    read_en_n = 1'b1;
    pops = 0;
    rwait(2);
    chk(pops, 0, "no pop");
    read_chip_select_n = 1'b0;
    read_en_n = 1'b0;
    addr = 8'h42;
    sel = 1'b1;
    rwait(1);
    chk(token, 1'b1, "token on deselect");
    sel = 1'b0;
    rwait(2);
    chk(read_queue, 5'h02, "queue kept");
    chk(read_data_oe, 1'b0, "bus off deselected");
    chk(token, 1'b0, "token one period");
    chk(flag_oe, 1'b0, "flag bus off deselected");
    // Second master reset: no serial load, the loaded word is kept, polled flag bus
    master_reset_n = 1'b0;
    flag_direct = 1'b0;
    serial_prog = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk(read_data_oe, 1'b0, "bus off in master reset");
    chk(done_n, 1'b1, "done in master reset");
    master_reset_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk(done_n, 1'b0, "done after defaults");
    rwait(1);
    bus1 = almost_empty_flag_bus;
    rwait(1);
    k = 16;
    for (int j = 0; j < 16; j++) if (8'(~AE[j*8 +: 8]) == bus1) k = j;
    chk(k < 16, 1'b1, "polled bus quadrant");
    chk(almost_empty_flag_bus, 8'(~AE[((k + 1) % 16) * 8 +: 8]), "polled bus step");
    report_and_stop();
  end
endmodule // test_multiqueue_read_port_serial_config
